// ---- include/rms_power_pkg.sv ----
// Constants, register map and arithmetic sizes of the per-phase rms and power datapath.
// Assumes a 20 MHz master clock and an APB register port with 32-bit data.
`default_nettype none
package rms_power_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int ADDR_W = 8;
  localparam int NPH = 3;
  // Per-phase register offsets, phase p at PHASE_STRIDE * p.
  localparam logic [7:0] PHASE_STRIDE = 8'h20;
  localparam logic [4:0] OFS_VRMS = 5'h00;
  localparam logic [4:0] OFS_VRMS_OS = 5'h04;
  localparam logic [4:0] OFS_VRMS_GAIN = 5'h08;
  localparam logic [4:0] OFS_WATTHR = 5'h0c;
  localparam logic [4:0] OFS_WATT_OS = 5'h10;
  localparam logic [4:0] OFS_WATT_GAIN = 5'h14;
  localparam logic [4:0] OFS_APPARENT = 5'h18;
  localparam logic [7:0] ADDR_COMP_MODE = 8'h60;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h64;
  localparam logic [7:0] ADDR_INT_MASK = 8'h68;
  localparam logic [7:0] ADDR_PULSE_NUM = 8'h6c;
  // Field positions.
  localparam int MODE_SEL_LSB = 0;
  localparam int PHASE_SEL_LSB = 2;
  localparam int REVERSAL_BIT = 17;
  localparam int NEG_A_BIT = 15;
  localparam int NUM_FREE_W = 13;
  // Values after reset.
  localparam logic [11:0] CAL_RESET = 12'h000;
  localparam logic [4:0] COMP_MODE_RESET = 5'h1c;
  localparam logic [12:0] PULSE_NUM_RESET = 13'h0000;
  // Update rates in master clocks.
  localparam int RMS_UPDATE_CYC = 12;
  localparam int PWR_UPDATE_CYC = 4;
  // Filter time constants, rounded to the power of two just below.
  localparam int VRMS_TAU_MS = 100;
  localparam int PWR_TAU_MS = 160;
  localparam int VRMS_SHIFT_DEF = $clog2(VRMS_TAU_MS * (CLK_HZ / 1000) / RMS_UPDATE_CYC) - 1;
  localparam int PWR_SHIFT_DEF = $clog2(PWR_TAU_MS * (CLK_HZ / 1000) / PWR_UPDATE_CYC) - 1;
  // Arithmetic scaling.
  localparam int GAIN_ONE = 4096;
  localparam int GAIN_SHIFT = 12;
  localparam int VRMS_SAMPLE_SHIFT = 8;
  localparam logic [8:0] MEAN_TO_RMS = 9'h11c;
  localparam int VRMS_OS_SHIFT = 6;
  localparam int PROD_SHIFT = 14;
  localparam int PWR_FRAC = 4;
  localparam int ENERGY_W = 41;
endpackage
`default_nettype wire

// ---- rtl/rms_power.sv ----
// Three-phase voltage rms, active power, energy and power-reversal datapath with an APB slave.
// Assumes sample inputs come from logic on CLK and are held between updates.
`timescale 1ns/1ps
`default_nettype none
module rms_power #(
  parameter int VRMS_SHIFT = rms_power_pkg::VRMS_SHIFT_DEF,
  parameter int PWR_SHIFT = rms_power_pkg::PWR_SHIFT_DEF
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [rms_power_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic signed [15:0] V_A,
  input wire logic signed [15:0] V_B,
  input wire logic signed [15:0] V_C,
  input wire logic signed [23:0] I_A,
  input wire logic signed [23:0] I_B,
  input wire logic signed [23:0] I_C,
  input wire logic [23:0] IRMS_A,
  input wire logic [23:0] IRMS_B,
  input wire logic [23:0] IRMS_C,
  output logic [2:0] PULSE_PHASE_EN,
  output logic IRQ_N
);
  import rms_power_pkg::*;

  // ***********************************************************
  // Saturation helpers
  // ***********************************************************
  function automatic logic signed [15:0] sat16(input logic signed [16:0] x);
    if (x > 17'sd32767)
      sat16 = 16'sh7fff;
    else if (x < -17'sd32768)
      sat16 = -16'sh8000;
    else
      sat16 = x[15:0];
  endfunction

  function automatic logic [23:0] satu24(input logic signed [26:0] x);
    if (x < 27'sd0)
      satu24 = 24'h000000;
    else if (x > 27'sh0ffffff)
      satu24 = 24'hffffff;
    else
      satu24 = x[23:0];
  endfunction

  function automatic logic signed [31:0] sat32(input logic signed [32:0] x);
    if (x > 33'sh07fffffff)
      sat32 = 32'sh7fffffff;
    else if (x < -33'sh080000000)
      sat32 = -32'sh80000000;
    else
      sat32 = x[31:0];
  endfunction

  // ***********************************************************
  // Update tick dividers
  // ***********************************************************
  logic [3:0] rms_div_reg;
  logic [1:0] pwr_div_reg;
  logic rms_tick;
  logic pwr_tick;

  assign rms_tick = (rms_div_reg == 4'(RMS_UPDATE_CYC - 1));
  assign pwr_tick = (pwr_div_reg == 2'(PWR_UPDATE_CYC - 1));

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rms_div_reg <= 4'h0;
    else if (rms_tick)
      rms_div_reg <= 4'h0;
    else
      rms_div_reg <= rms_div_reg + 4'h1;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      pwr_div_reg <= 2'h0;
    else
      pwr_div_reg <= pwr_div_reg + 2'h1;
  end

  // ***********************************************************
  // Software registers
  // ***********************************************************
  logic [11:0] vrms_os_reg [NPH];
  logic [11:0] vrms_gain_reg [NPH];
  logic [11:0] watt_os_reg [NPH];
  logic [11:0] watt_gain_reg [NPH];
  logic [4:0] comp_mode_reg;
  logic reversal_reg;
  logic reversal_mask_reg;
  logic [12:0] pulse_num_reg;
  logic [23:0] vrms_reg [NPH];
  logic [23:0] apparent_reg [NPH];
  logic [ENERGY_W-1:0] energy_reg [NPH];
  logic [NPH-1:0] neg_reg;
  logic [NPH-1:0] sign_flip;
  logic [1:0] mode_sel;
  logic [2:0] phase_sel;
  logic wr_en;
  logic setup;
  logic [1:0] ph_idx;
  logic ph_hit;

  assign mode_sel = comp_mode_reg[MODE_SEL_LSB +: 2];
  assign phase_sel = comp_mode_reg[PHASE_SEL_LSB +: 3];
  assign PULSE_PHASE_EN = phase_sel;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign setup = PSEL && !PENABLE;
  assign ph_idx = PADDR[6:5];
  assign ph_hit = (PADDR[7] == 1'b0) && (ph_idx != 2'd3);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int p = 0; p < NPH; p++)
      begin
        vrms_os_reg[p] <= CAL_RESET;
        vrms_gain_reg[p] <= CAL_RESET;
        watt_os_reg[p] <= CAL_RESET;
        watt_gain_reg[p] <= CAL_RESET;
      end
      comp_mode_reg <= COMP_MODE_RESET;
      reversal_mask_reg <= 1'b0;
      pulse_num_reg <= PULSE_NUM_RESET;
    end
    else if (wr_en)
    begin
      if (ph_hit)
      begin
        unique case (PADDR[4:0])
          OFS_VRMS_OS: vrms_os_reg[ph_idx] <= PWDATA[11:0];
          OFS_VRMS_GAIN: vrms_gain_reg[ph_idx] <= PWDATA[11:0];
          OFS_WATT_OS: watt_os_reg[ph_idx] <= PWDATA[11:0];
          OFS_WATT_GAIN: watt_gain_reg[ph_idx] <= PWDATA[11:0];
          default: ;
        endcase
      end
      else if (PADDR == ADDR_COMP_MODE)
        comp_mode_reg <= PWDATA[4:0];
      else if (PADDR == ADDR_INT_MASK)
        reversal_mask_reg <= PWDATA[REVERSAL_BIT];
      else if (PADDR == ADDR_PULSE_NUM)
        pulse_num_reg <= PWDATA[NUM_FREE_W-1:0];
    end
  end

  // Write one to clear; a sign change in the same cycle keeps the flag set.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      reversal_reg <= 1'b0;
    else if (|(sign_flip & phase_sel))
      reversal_reg <= 1'b1;
    else if (wr_en && PADDR == ADDR_INT_STATUS && PWDATA[REVERSAL_BIT])
      reversal_reg <= 1'b0;
  end

  assign IRQ_N = !(reversal_reg && reversal_mask_reg);

  // ***********************************************************
  // APB read path, captured in the setup cycle
  // ***********************************************************
  logic [31:0] rd_data;
  logic rd_ok;

  always_comb
  begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    if (ph_hit)
    begin
      unique case (PADDR[4:0])
        OFS_VRMS: rd_data = {8'h00, vrms_reg[ph_idx]};
        OFS_VRMS_OS: rd_data = {20'h00000, vrms_os_reg[ph_idx]};
        OFS_VRMS_GAIN: rd_data = {20'h00000, vrms_gain_reg[ph_idx]};
        OFS_WATTHR: rd_data = {16'h0000, energy_reg[ph_idx][ENERGY_W-1 -: 16]};
        OFS_WATT_OS: rd_data = {20'h00000, watt_os_reg[ph_idx]};
        OFS_WATT_GAIN: rd_data = {20'h00000, watt_gain_reg[ph_idx]};
        OFS_APPARENT: rd_data = {8'h00, apparent_reg[ph_idx]};
        default: rd_ok = 1'b0;
      endcase
    end
    else if (PADDR == ADDR_COMP_MODE)
      rd_data = {27'h0000000, comp_mode_reg};
    else if (PADDR == ADDR_INT_STATUS)
      rd_data = 32'(reversal_reg) << REVERSAL_BIT;
    else if (PADDR == ADDR_INT_MASK)
      rd_data = 32'(reversal_mask_reg) << REVERSAL_BIT;
    else if (PADDR == ADDR_PULSE_NUM)
      rd_data = {16'h0000, neg_reg[0], neg_reg[1], neg_reg[2], pulse_num_reg};
    else
      rd_ok = 1'b0;
  end

  logic err_reg;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA <= 32'h00000000;
      err_reg <= 1'b0;
    end
    else if (setup)
    begin
      PRDATA <= PWRITE ? 32'h00000000 : rd_data;
      err_reg <= !rd_ok;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && err_reg;

  // ***********************************************************
  // Per-phase datapath
  // ***********************************************************
  logic signed [15:0] v_in [NPH];
  logic signed [23:0] i_in [NPH];
  logic [23:0] irms_in [NPH];

  assign v_in[0] = V_A;
  assign v_in[1] = V_B;
  assign v_in[2] = V_C;
  assign i_in[0] = I_A;
  assign i_in[1] = I_B;
  assign i_in[2] = I_C;
  assign irms_in[0] = IRMS_A;
  assign irms_in[1] = IRMS_B;
  assign irms_in[2] = IRMS_C;

  for (genvar p = 0; p < NPH; p++)
  begin : g_phase
    logic signed [13:0] vgain;
    logic signed [29:0] vprod;
    logic signed [15:0] vcorr;
    logic [15:0] vabs;
    logic [47:0] vfilt_reg;
    logic [23:0] vmean;
    logic [32:0] vscaled;
    logic signed [26:0] vsum;
    logic signed [24:0] isel;
    logic signed [40:0] prod;
    logic signed [26:0] mult;
    logic signed [47:0] pfilt_reg;
    logic signed [26:0] plp;
    logic signed [31:0] pq;
    logic signed [13:0] wgain;
    logic signed [44:0] pg;
    logic signed [31:0] power;
    logic use_zero;
    logic [47:0] app;

    // One extra bit keeps 1 + G/4096 positive up to 6143 counts.
    assign vgain = 14'(GAIN_ONE) + 14'(signed'(vrms_gain_reg[p]));
    assign vprod = v_in[p] * vgain;
    assign vcorr = sat16(17'(vprod >>> GAIN_SHIFT));
    assign vabs = vcorr[15] ? 16'(-vcorr) : 16'(vcorr);
    assign vmean = 24'(vfilt_reg >> VRMS_SHIFT);
    // Mean absolute value of a sine is its rms over 1.11; the constant folds that and the x256 scale.
    assign vscaled = (33'(vmean) * 33'(MEAN_TO_RMS)) >> VRMS_SAMPLE_SHIFT;
    assign vsum = 27'(vscaled[25:0]) + (27'(signed'(vrms_os_reg[p])) <<< VRMS_OS_SHIFT);

    // One-pole filter over absolute samples; its time constant sets settling and bandwidth.
    always_ff @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        vfilt_reg <= 48'h0;
      else if (rms_tick)
        vfilt_reg <= vfilt_reg + (48'(vabs) << VRMS_SAMPLE_SHIFT) - (vfilt_reg >> VRMS_SHIFT);
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        vrms_reg[p] <= 24'h000000;
      else if (rms_tick)
        vrms_reg[p] <= satu24(vsum);
    end

    assign app = 48'(vrms_reg[p]) * 48'(irms_in[p]);

    always_ff @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        apparent_reg[p] <= 24'h000000;
      else if (rms_tick)
        apparent_reg[p] <= app[47:24];
    end

    // Outer phases may use a current difference with phase B; phase B energy stops in every mode but 0.
    if (p == 1)
    begin : g_mid
      assign isel = 25'(i_in[p]);
      assign use_zero = (mode_sel != 2'd0);
    end
    else
    begin : g_outer
      assign isel = ((mode_sel == 2'd1) || (mode_sel == 2'd2 && p == 0)) ?
        25'(i_in[p]) - 25'(i_in[1]) : 25'(i_in[p]);
      assign use_zero = 1'b0;
    end

    assign prod = 41'(v_in[p]) * 41'(isel);
    assign mult = 27'(prod >>> PROD_SHIFT);
    assign plp = 27'(pfilt_reg >>> PWR_SHIFT);
    assign pq = sat32(33'(plp) * 33'sd16 + 33'(signed'(watt_os_reg[p])));
    assign wgain = 14'(GAIN_ONE) + 14'(signed'(watt_gain_reg[p]));
    assign pg = 45'(pq) * 45'(wgain);
    assign power = sat32(33'(pg >>> GAIN_SHIFT));

    always_ff @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        pfilt_reg <= 48'sh0;
      else if (pwr_tick)
        pfilt_reg <= pfilt_reg + 48'(mult) - (pfilt_reg >>> PWR_SHIFT);
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        energy_reg[p] <= '0;
      else if (pwr_tick && !use_zero)
        energy_reg[p] <= energy_reg[p] + ENERGY_W'(power >>> PWR_FRAC);
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
      if (!RST_N)
        neg_reg[p] <= 1'b0;
      else if (pwr_tick)
        neg_reg[p] <= power[31];
    end

    assign sign_flip[p] = pwr_tick && (power[31] != neg_reg[p]);
  end

endmodule
`default_nettype wire

// ---- tb/rms_power_props.sv ----
// Checker for the register port, phase selection and interrupt output of rms_power.
// Assumes it is bound to rms_power and sees only its top-level ports.
`timescale 1ns/1ps
`default_nettype none
module rms_power_props
  import rms_power_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [rms_power_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [2:0] PULSE_PHASE_EN,
  input wire logic IRQ_N
);
  // ****************************************
  // Helper logic and properties
  // ****************************************
  logic acc;
  logic rd;
  logic mapped;
  logic mask_q;
  logic [2:0] sel_w;
  assign acc = PSEL && PENABLE;
  assign rd = acc && !PWRITE;
  assign sel_w = PWDATA[PHASE_SEL_LSB+:3];
  assign mapped = PADDR[1:0] == 2'h0 && (PADDR < ADDR_COMP_MODE ? PADDR[4:0] <= OFS_APPARENT : PADDR <= ADDR_PULSE_NUM);
  // Shadow of the reversal mask bit, so the interrupt can be tied to it.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      mask_q <= 1'b0;
    else if (acc && PWRITE && PADDR == ADDR_INT_MASK)
      mask_q <= PWDATA[REVERSAL_BIT];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ready_access: assert property (acc |-> PREADY) else $error("ready low in access phase");
  a_error_unmapped: assert property (acc |-> PSLVERR == !mapped) else $error("error flag does not match decode");
  a_error_outside: assert property (PSLVERR |-> acc) else $error("error flag outside access phase");
  a_irq_needs_mask: assert property (!IRQ_N |-> mask_q)
    else $error("interrupt low with mask clear");
  a_phase_sel_write: assert property (acc && PWRITE && PADDR == ADDR_COMP_MODE |=> PULSE_PHASE_EN == $past(sel_w))
    else $error("phase enables not taken from write");
  a_mode_readback: assert property (rd && PADDR == ADDR_COMP_MODE |-> PRDATA[31:5] == 27'h0 && PRDATA[4:2] == PULSE_PHASE_EN)
    else $error("mode read differs from phase enables");
  a_vrms_width: assert property (rd && PADDR < ADDR_COMP_MODE && PADDR[4:0] == OFS_VRMS |-> PRDATA[31:24] == 8'h00)
    else $error("voltage rms wider than 24 bits");
  a_reset_idle: assert property ($rose(RST_N) |-> IRQ_N && PULSE_PHASE_EN == 3'h7)
    else $error("outputs not idle after reset");
  cover property (!IRQ_N);
  cover property (acc && PSLVERR);
  cover property (rd && PADDR == ADDR_INT_STATUS && PRDATA[REVERSAL_BIT]);
endmodule

bind rms_power rms_power_props rms_power_props_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PULSE_PHASE_EN(PULSE_PHASE_EN), .IRQ_N(IRQ_N));
`default_nettype wire

// ---- tb/rms_power_test.sv ----
// Self-checking bench for rms_power: register access, rms, energy and reversal flag.
// Assumes short filter shifts so that results settle within a few thousand clocks.
`timescale 1ns/1ps
`default_nettype none
module rms_power_test;
  import rms_power_pkg::*;
  // ****************************************
  // Stimulus, tasks and test sequence
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_n;
  logic [2:0] sel_en;
  logic signed [15:0] v [3] = '{16'sd1000, -16'sd2000, 16'sd500};
  logic signed [23:0] i [3] = '{default: 24'sh0};
  logic [23:0] irms = 24'h800000;
  logic [4:0] cal [4] = '{OFS_VRMS_OS, OFS_VRMS_GAIN, OFS_WATT_OS, OFS_WATT_GAIN};
  logic [31:0] b [3];
  logic [31:0] q;
  logic [31:0] q0;
  logic e;
  int fails = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  rms_power #(.VRMS_SHIFT(4), .PWR_SHIFT(4)) rms_power_i (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .V_A(v[0]), .V_B(v[1]), .V_C(v[2]), .I_A(i[0]), .I_B(i[1]), .I_C(i[2]),
    .IRMS_A(irms), .IRMS_B(irms), .IRMS_C(irms), .PULSE_PHASE_EN(sel_en), .IRQ_N(irq_n));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  function automatic logic [31:0] near(input logic [31:0] s, input int x, input int t);
    return {31'h0, int'(s) >= x - t && int'(s) <= x + t};
  endfunction
  function automatic logic [7:0] pa(input int p, input logic [4:0] o);
    return PHASE_STRIDE * 8'(p) + {3'h0, o};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50)
      fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(n, q, x);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fails++;
    print_verdict();
  end
  initial
  begin
    int n;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("phase enables", {29'h0, sel_en}, 32'h7);
    rd_chk("comp mode", ADDR_COMP_MODE, 32'h1c);
    rd_chk("pulse num", ADDR_PULSE_NUM, 32'h0);
    apb(1'b1, 8'h70, 32'h1);
    check("unmapped err", {31'h0, e}, 32'h1);
    rd_chk("unmapped", 8'h70, 32'h0);
    apb(1'b1, pa(0, OFS_VRMS), 32'h1234);
    check("ro err", {31'h0, e}, 32'h0);
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 4; k++)
      begin
        rd_chk("cal reset", pa(p, cal[k]), 32'h0);
        apb(1'b1, pa(p, cal[k]), 32'hffff_f800);
        rd_chk("cal low", pa(p, cal[k]), 32'h800);
        apb(1'b1, pa(p, cal[k]), 32'h7ff);
        rd_chk("cal high", pa(p, cal[k]), 32'h7ff);
        apb(1'b1, pa(p, cal[k]), 32'h0);
      end
    repeat (3000) @(posedge clk);
    for (int p = 0; p < 3; p++)
    begin
      apb(1'b0, pa(p, OFS_VRMS), 32'h0);
      b[p] = q;
      check("vrms", near(q, 284 * (v[p] < 0 ? -v[p] : v[p]), 3000), 32'h1);
      apb(1'b0, pa(p, OFS_APPARENT), 32'h0);
      check("apparent", near(q, int'(b[p] >> 1), 2), 32'h1);
    end
    apb(1'b1, pa(0, OFS_VRMS_OS), 32'h10);
    repeat (50) @(posedge clk);
    rd_chk("vrms offset up", pa(0, OFS_VRMS), b[0] + 32'd1024);
    apb(1'b1, pa(0, OFS_VRMS_OS), 32'hff0);
    repeat (50) @(posedge clk);
    rd_chk("vrms offset down", pa(0, OFS_VRMS), b[0] - 32'd1024);
    apb(1'b1, pa(0, OFS_VRMS_OS), 32'h0);
    repeat (50) @(posedge clk);
    rd_chk("vrms stable", pa(0, OFS_VRMS), b[0]);
    apb(1'b1, pa(0, OFS_VRMS_GAIN), 32'h800);
    repeat (3000) @(posedge clk);
    apb(1'b0, pa(0, OFS_VRMS), 32'h0);
    check("vrms half", near(q, 142000, 1500), 32'h1);
    v[0] <= 16'sh7fff;
    apb(1'b1, pa(0, OFS_VRMS_GAIN), 32'h7ff);
    repeat (3000) @(posedge clk);
    apb(1'b0, pa(0, OFS_VRMS), 32'h0);
    check("vrms saturated", near(q, 9305828, 93000), 32'h1);
    v[0] <= 16'sd1000;
    apb(1'b1, pa(0, OFS_VRMS_GAIN), 32'h0);
    i[0] <= 24'sh400000;
    repeat (2000) @(posedge clk);
    apb(1'b0, pa(0, OFS_WATTHR), 32'h0);
    q0 = q;
    repeat (4000) @(posedge clk);
    apb(1'b0, pa(0, OFS_WATTHR), 32'h0);
    check("energy rise", near(32'(q[15:0] - q0[15:0]), 8, 1), 32'h1);
    apb(1'b1, ADDR_INT_MASK, 32'h20000);
    apb(1'b1, ADDR_INT_STATUS, 32'h20000);
    check("irq quiet", {31'h0, irq_n}, 32'h1);
    i[0] <= 24'shc00000;
    for (n = 0; n < 2000 && irq_n !== 1'b0; n++)
      @(posedge clk);
    check("irq on reversal", {31'h0, irq_n}, 32'h0);
    rd_chk("flag set", ADDR_INT_STATUS, 32'h20000);
    rd_chk("neg bits", ADDR_PULSE_NUM, 32'h8000);
    apb(1'b1, ADDR_INT_STATUS, 32'h20000);
    rd_chk("flag cleared", ADDR_INT_STATUS, 32'h0);
    apb(1'b1, ADDR_COMP_MODE, 32'h18);
    check("sel b c", {29'h0, sel_en}, 32'h6);
    i[0] <= 24'sh400000;
    repeat (1000) @(posedge clk);
    rd_chk("unselected", ADDR_INT_STATUS, 32'h0);
    check("irq idle", {31'h0, irq_n}, 32'h1);
    rd_chk("neg gone", ADDR_PULSE_NUM, 32'h0);
    apb(1'b1, ADDR_COMP_MODE, 32'h1c);
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    i[0] <= 24'shc00000;
    repeat (1000) @(posedge clk);
    rd_chk("flag masked", ADDR_INT_STATUS, 32'h20000);
    check("irq masked", {31'h0, irq_n}, 32'h1);
    i[1] <= 24'sh400000;
    apb(1'b1, ADDR_COMP_MODE, 32'h1d);
    apb(1'b0, pa(1, OFS_WATTHR), 32'h0);
    q0 = q;
    repeat (2000) @(posedge clk);
    rd_chk("b frozen", pa(1, OFS_WATTHR), q0);
    apb(1'b1, ADDR_COMP_MODE, 32'h1c);
    repeat (2000) @(posedge clk);
    apb(1'b0, pa(1, OFS_WATTHR), 32'h0);
    check("b runs", {31'h0, q !== q0}, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
